// ===== common/tofl_pkg.sv
/*
  Constants for the timer output-mode and input-filter block.
  Assumes an APB slave with 32-bit data and byte strobes.
*/
package tofl_pkg;
  // Register indices; each register's byte address is four times its index.
  localparam logic [31:0] IDX_NFEN = 32'h000f_0071;
  localparam logic [31:0] IDX_ISC = 32'h000f_0073;
  localparam logic [31:0] IDX_TOM = 32'h000f_01be;
  localparam logic [31:0] IDX_TOL = 32'h0000_0010;
  localparam logic [31:0] IDX_TOE = 32'h0000_0011;
  localparam logic [31:0] IDX_STAT = 32'h0000_0012;
  // Byte addresses derived from the indices.
  localparam logic [31:0] ADDR_NFEN = {IDX_NFEN[29:0], 2'b00};
  localparam logic [31:0] ADDR_ISC = {IDX_ISC[29:0], 2'b00};
  localparam logic [31:0] ADDR_TOM = {IDX_TOM[29:0], 2'b00};
  localparam logic [31:0] ADDR_TOL = {IDX_TOL[29:0], 2'b00};
  localparam logic [31:0] ADDR_TOE = {IDX_TOE[29:0], 2'b00};
  localparam logic [31:0] ADDR_STAT = {IDX_STAT[29:0], 2'b00};
  // Reset values.
  localparam logic [15:0] RST_TOM = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Field positions and masks.
  localparam int ISC_CH7 = 1;
  localparam int ISC_INT0 = 0;
  localparam int NF_RSVD = 2;
  localparam int CH7 = 7;
  localparam logic [7:0] NFEN_MASK = 8'hfb;
  localparam logic [1:0] ISC_MASK = 2'h3;
  localparam int NCH = 8;
endpackage : tofl_pkg

// ===== logic/tofl_in_cond.sv
/*
  Input conditioner: a two-flop synchroniser followed by an optional
  two-cycle level filter. Assumes pin_in is asynchronous to pclk.
*/
`timescale 1ns/100ps
module tofl_in_cond (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Raw pin and filter enable.
  input wire logic pin_in,
  input wire logic filt_en,
  // Synchronised and conditioned levels.
  output logic sync_out,
  output logic cond_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic out;
  } tofl_cond_s;

  tofl_cond_s st_ff;
  tofl_cond_s nxt_st;

  // The first flop feeds only the second; the filter looks at s2 and s3.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = pin_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    if (filt_en) begin
      if (st_ff.s2 == st_ff.s3) begin
        nxt_st.out = st_ff.s2; // RQ15
      end
    end else begin
      nxt_st.out = st_ff.s2; // RQ16
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sync_out = st_ff.s2;
  assign cond_out = st_ff.out;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A filtered level only moves after two equal synchronised samples.
  chk_filter_hold: assert property ($past(filt_en) && $changed(st_ff.out) // RQ15
      |-> $past(st_ff.s2) == $past(st_ff.s3))
    else $error("Filter passed a level held less than two cycles.");
  // Without the filter the output follows the synchroniser by one cycle.
  chk_filter_bypass: assert property (!filt_en |=> st_ff.out == $past(st_ff.s2)) // RQ16
    else $error("Unfiltered input did not follow synchroniser.");
endmodule : tofl_in_cond

// ===== logic/tofl_top.sv
/*
  Timer output-mode, output-level and input-conditioning block with an
  APB register slave. Assumes channel interrupt pulses come from the
  counter core on pclk and that timer and serial pins are asynchronous.
*/
// The APB interface to the registers was decided locally.
// Function
// RQ1: A polarity change takes effect at the next output transition.
// RQ2: Polarity bit 1 drives the channel output active-low.
// RQ3: Polarity bit 0 drives the channel output active-high.
// RQ4: Polarity is ignored in master output mode.
// RQ5: Mode 0 toggles the output on the channel's own interrupt.
// RQ6: Mode 1 sets on master interrupt, clears on own interrupt.
// RQ7: Mode change applies at next set or reset while output enabled.
// RQ8: Software uses mode 0 for masters and independent channels, 1 for slaves.
// RQ9: Output-mode register resets to zero; 16-bit or low-byte writes.
// RQ10: Software keeps mode and polarity bits 15 to 8 and 0 zero.
// RQ11: Channel-7 select 1 feeds serial receive line to channel 7.
// RQ12: Channel-7 select 0 uses the channel-7 timer input pin.
// RQ13: Interrupt select routes serial receive line or its pin to interrupt 0.
// RQ14: Input switch register resets to zero; bits 7 to 2 stay zero.
// RQ15: Enabled filter synchronises then needs two equal cycles.
// RQ16: Disabled filter only synchronises the input.
// RQ17: Filter enable register has one bit per channel; bit 2 reserved.
// RQ18: Filter enable register resets to zero; byte writes accepted.
// RQ19: Channel-7 filter bit acts on whichever source is selected.
// RQ20: Software clears port bits to use a shared pin as output.
// RQ21: Software sets port direction to input to use a shared pin as input.
`timescale 1ns/100ps
module tofl_top (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Counter core interrupt pulses, one per channel.
  input wire logic [7:0] channel_timer_interrupt,
  // Pins.
  input wire logic [7:0] timer_in_pin,
  input wire logic serial_receive_line,
  input wire logic ext_int0_pin,
  // Outputs to pins and to the counter core.
  output logic [7:0] timer_out_pin,
  output logic [7:0] timer_in_cond,
  output logic external_interrupt_0
);
  typedef struct packed {
    logic [15:0] tom;
    logic [7:0] tol;
    logic [7:0] toe;
    logic [1:0] input_switch_control;
    logic [7:0] nfen;
    logic [7:0] level;
    logic [7:0] pol_eff;
    logic [7:0] pin;
    logic [7:0] tin;
    logic int0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tofl_top_s;

  tofl_top_s st_ff;
  tofl_top_s nxt_st;

  logic [7:0] sync_v;
  logic [7:0] cond_v;
  logic rxd_sync;
  logic rxd_cond;
  logic int0_sync;
  logic ti7_cond;
  logic [7:0] filt_en;
  logic [7:0] mst_irq;
  logic [7:0] tog_v;
  logic [7:0] set_v;
  logic [7:0] rst_v;
  logic [7:0] ev_v;
  logic setup;
  logic access;
  logic hit;
  logic [31:0] rdata;

  // Channel 7 filter bit also guards the serial receive line.
  assign filt_en = st_ff.nfen; // RQ19

  // One conditioner per timer input pin.
  genvar g;
  generate
    for (g = 0; g < tofl_pkg::NCH; g++) begin : g_in
      tofl_in_cond u_cond (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(timer_in_pin[g]),
        .filt_en(filt_en[g]),
        .sync_out(sync_v[g]),
        .cond_out(cond_v[g])
      );
    end
  endgenerate

  // Serial receive line, filtered with the channel 7 enable.
  tofl_in_cond u_rxd (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(serial_receive_line),
    .filt_en(filt_en[tofl_pkg::CH7]),
    .sync_out(rxd_sync),
    .cond_out(rxd_cond)
  );

  // External interrupt pin, synchronised only.
  tofl_in_cond u_int0 (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(ext_int0_pin),
    .filt_en(1'b0),
    .sync_out(int0_sync),
    .cond_out()
  );

  assign ti7_cond = cond_v[tofl_pkg::CH7];

  // Master interrupt per channel: nearest lower channel in master mode.
  always_comb begin
    logic found;
    found = 1'b0;
    mst_irq = '0;
    for (int n = 1; n < tofl_pkg::NCH; n++) begin
      found = 1'b0;
      for (int k = n - 1; k >= 0; k--) begin
        if (!found && !st_ff.tom[k]) begin
          found = 1'b1;
          mst_irq[n] = channel_timer_interrupt[k];
        end
      end
    end
  end

  // Output events classified by the programmed mode.
  always_comb begin
    for (int n = 0; n < tofl_pkg::NCH; n++) begin
      tog_v[n] = !st_ff.tom[n] && channel_timer_interrupt[n]; // RQ5
      set_v[n] = st_ff.tom[n] && mst_irq[n]; // RQ6
      rst_v[n] = st_ff.tom[n] && channel_timer_interrupt[n]; // RQ6
      ev_v[n] = st_ff.toe[n] && (tog_v[n] || set_v[n] || rst_v[n]);
    end
  end

  // Bus phase decode and read mux.
  assign setup = psel && !penable;
  assign access = psel && penable && st_ff.pready;
  always_comb begin
    hit = 1'b1;
    rdata = '0;
    unique case (paddr)
      tofl_pkg::ADDR_NFEN: rdata[7:0] = st_ff.nfen;
      tofl_pkg::ADDR_ISC: rdata[1:0] = st_ff.input_switch_control;
      tofl_pkg::ADDR_TOM: rdata[15:0] = st_ff.tom;
      tofl_pkg::ADDR_TOL: rdata[7:0] = st_ff.tol;
      tofl_pkg::ADDR_TOE: rdata[7:0] = st_ff.toe;
      tofl_pkg::ADDR_STAT: rdata[15:0] = {st_ff.tin, st_ff.pin};
      default: hit = 1'b0;
    endcase
  end

  // Next-state logic for outputs, inputs and registers.
  always_comb begin
    nxt_st = st_ff;
    // Output level and latched polarity per channel.
    for (int n = 0; n < tofl_pkg::NCH; n++) begin
      if (ev_v[n]) begin
        if (tog_v[n]) begin
          nxt_st.level[n] = !st_ff.level[n]; // RQ5
        end else if (rst_v[n]) begin
          nxt_st.level[n] = 1'b0; // RQ6
        end else begin
          nxt_st.level[n] = 1'b1; // RQ6
        end
        // Mode and polarity are sampled only at a transition.
        nxt_st.pol_eff[n] = st_ff.tom[n] && st_ff.tol[n]; // RQ1 RQ4 RQ7
      end
    end
    nxt_st.pin = nxt_st.level ^ nxt_st.pol_eff; // RQ2 RQ3
    // Input routing.
    nxt_st.tin = cond_v;
    if (st_ff.input_switch_control[tofl_pkg::ISC_CH7]) begin
      nxt_st.tin[tofl_pkg::CH7] = rxd_cond; // RQ11
    end else begin
      nxt_st.tin[tofl_pkg::CH7] = ti7_cond; // RQ12
    end
    nxt_st.int0 = st_ff.input_switch_control[tofl_pkg::ISC_INT0] ? rxd_sync : int0_sync; // RQ13
    // Answer is prepared in setup and shown in the first access cycle.
    nxt_st.pready = setup;
    nxt_st.pslverr = setup && !hit;
    if (setup) begin
      nxt_st.prdata = pwrite ? '0 : rdata;
    end
    // Writes take effect at the completing access edge.
    if (access && pwrite && !st_ff.pslverr) begin
      unique case (paddr)
        tofl_pkg::ADDR_NFEN: begin
          if (pstrb[0]) begin
            nxt_st.nfen = pwdata[7:0] & tofl_pkg::NFEN_MASK; // RQ17 RQ18
          end
        end
        tofl_pkg::ADDR_ISC: begin
          if (pstrb[0]) begin
            nxt_st.input_switch_control = pwdata[1:0] & tofl_pkg::ISC_MASK; // RQ14
          end
        end
        tofl_pkg::ADDR_TOM: begin
          if (pstrb[0]) begin
            nxt_st.tom[7:0] = pwdata[7:0]; // RQ9
          end
          if (pstrb[1]) begin
            nxt_st.tom[15:8] = pwdata[15:8]; // RQ9
          end
        end
        tofl_pkg::ADDR_TOL: begin
          if (pstrb[0]) begin
            nxt_st.tol = pwdata[7:0];
          end
        end
        tofl_pkg::ADDR_TOE: begin
          if (pstrb[0]) begin
            nxt_st.toe = pwdata[7:0];
          end
        end
        default: begin
          nxt_st.tol = st_ff.tol;
        end
      endcase
    end
  end

  // State register; reset clears every register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.tom <= tofl_pkg::RST_TOM; // RQ9
      st_ff.input_switch_control <= tofl_pkg::RST_BYTE[1:0]; // RQ14
      st_ff.nfen <= tofl_pkg::RST_BYTE; // RQ18
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Port drivers, all straight from the state register.
  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign timer_out_pin = st_ff.pin;
  assign timer_in_cond = st_ff.tin;
  assign external_interrupt_0 = st_ff.int0;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Sequences of a low-byte output-mode write.
  sequence seq_tom_setup;
    setup && pwrite && paddr == tofl_pkg::ADDR_TOM && pstrb[1:0] == 2'b01;
  endsequence
  sequence seq_tom_access;
    access && pwrite;
  endsequence

  // A low-byte write leaves the upper byte alone.
  chk_tom_low_byte: assert property (seq_tom_setup ##1 seq_tom_access // RQ9
      |=> st_ff.tom[15:8] == $past(st_ff.tom[15:8], 2))
    else $error("Low-byte mode write disturbed the upper byte.");
  // Reserved filter bit never holds a one.
  chk_nfen_reserved: assert property (st_ff.nfen[tofl_pkg::NF_RSVD] == 1'b0) // RQ17
    else $error("Reserved filter enable bit set.");
  // A mode write leaves the input switch register alone.
  chk_isc_write: assert property (seq_tom_setup ##1 seq_tom_access |=> $stable(st_ff.input_switch_control)) // RQ14
    else $error("Mode write changed the input switch register.");
  // Channel 7 follows the selected source one cycle later.
  chk_ch7_route: assert property (st_ff.input_switch_control[tofl_pkg::ISC_CH7] // RQ11 RQ19
      |=> timer_in_cond[tofl_pkg::CH7] == $past(rxd_cond))
    else $error("Channel 7 did not follow the serial line.");
  chk_ch7_pin: assert property (!st_ff.input_switch_control[tofl_pkg::ISC_CH7] // RQ12
      |=> timer_in_cond[tofl_pkg::CH7] == $past(ti7_cond))
    else $error("Channel 7 did not follow its own pin.");
  chk_int0_route: assert property (st_ff.input_switch_control[tofl_pkg::ISC_INT0] // RQ13
      |=> external_interrupt_0 == $past(rxd_sync))
    else $error("Interrupt 0 did not follow the serial line.");
  // An unmapped access answers with an error in the first access cycle.
  chk_unmapped_err: assert property (setup && !hit |=> pready && pslverr)
    else $error("Unmapped address not refused.");

  // Per-channel output checks.
  generate
    for (g = 0; g < tofl_pkg::NCH; g++) begin : g_chk
      // Without a transition the pin holds, whatever the registers do.
      chk_pin_deferred: assert property (!ev_v[g] |=> $stable(timer_out_pin[g])) // RQ1 RQ7
        else $error("Pin moved without an output event.");
      // Master-mode toggle inverts the pin with polarity ignored.
      chk_toggle_master: assert property (ev_v[g] && tog_v[g] // RQ4 RQ5
          |=> st_ff.level[g] != $past(st_ff.level[g]) && timer_out_pin[g] == st_ff.level[g])
        else $error("Master toggle wrong.");
      // Slave reset drives the inactive level chosen by polarity.
      chk_slave_reset: assert property (ev_v[g] && rst_v[g] // RQ2 RQ3 RQ6
          |=> timer_out_pin[g] == $past(st_ff.tol[g]))
        else $error("Slave reset level wrong.");
      // Slave set drives the active level chosen by polarity.
      chk_slave_set: assert property (ev_v[g] && set_v[g] && !rst_v[g] // RQ2 RQ3 RQ6
          |=> timer_out_pin[g] == !$past(st_ff.tol[g]))
        else $error("Slave set level wrong.");
    end
  endgenerate
endmodule : tofl_top

// ===== verification/tofl_pin_model.sv
/*
  Model of the pins outside the block: timer inputs, serial receive line
  and the interrupt-0 pin, plus the pads that carry the timer outputs.
  Assumes the bench sets levels and one-cycle glitch masks just after pclk edges.
*/
`timescale 1ns/100ps
module tofl_pin_model (
  // Requested levels.
  input wire logic [7:0] pin_lvl,
  input wire logic ser_lvl,
  input wire logic int_lvl,
  // One-cycle glitch masks.
  input wire logic [7:0] pin_gl,
  input wire logic ser_gl,
  // Timer outputs from the block.
  input wire logic [7:0] timer_out_pin,
  // Pads of the shared output pins.
  output logic [7:0] out_pad,
  // Pins seen by the block.
  output logic [7:0] timer_in_pin,
  output logic serial_receive_line,
  output logic ext_int0_pin
);
  // Shared pins act as inputs to the block; a glitch inverts the level.
  assign timer_in_pin = pin_lvl ^ pin_gl;
  assign serial_receive_line = ser_lvl ^ ser_gl;
  assign ext_int0_pin = int_lvl;
  // Port bits are cleared, so the shared pins pass the timer level to the pad.
  assign out_pad = timer_out_pin;
endmodule : tofl_pin_model

// ===== verification/tofl_top_bench.sv
/*
  Self-checking bench for the timer output-mode and input-filter block.
  Assumes the pin model drives the pins and the bench acts as APB master.
*/
`timescale 1ns/100ps
module tofl_top_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] irq, pin_lvl, pin_gl, timer_in_pin, timer_out_pin, timer_in_cond, seen, out_pad;
  logic ser_lvl, ser_gl, int_lvl, serial_receive_line, ext_int0_pin, external_interrupt_0;
  int bad_count, comparisons;
  wire logic [31:0] out_w = {24'h00_0000, out_pad};
  wire logic [31:0] cond_w = {24'h00_0000, timer_in_cond};

  // Design and pin model.
  tofl_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .channel_timer_interrupt(irq), .timer_in_pin(timer_in_pin), .serial_receive_line(serial_receive_line),
    .ext_int0_pin(ext_int0_pin), .timer_out_pin(timer_out_pin), .timer_in_cond(timer_in_cond),
    .external_interrupt_0(external_interrupt_0));
  tofl_pin_model pins_u (.pin_lvl(pin_lvl), .ser_lvl(ser_lvl), .int_lvl(int_lvl), .pin_gl(pin_gl),
    .ser_gl(ser_gl), .timer_out_pin(timer_out_pin), .out_pad(out_pad), .timer_in_pin(timer_in_pin),
    .serial_receive_line(serial_receive_line), .ext_int0_pin(ext_int0_pin));

  // Clock of 20 ns period.
  always #10 pclk = ~pclk;

  // Compares one value and counts the result.
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Register write.
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, s, r, e);
  endtask : wr

  // Register read with data and error checks.
  task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, 4'h0, r, e);
    chk(nm, x, r);
    chk({nm, "_err"}, {31'h0000_0000, xe}, {31'h0000_0000, e});
  endtask : rd

  // One-cycle interrupt pulse, then time for the output to settle.
  task automatic fire(input logic [7:0] m);
    @(posedge pclk);
    irq <= m;
    @(posedge pclk);
    irq <= 8'h00;
    repeat (3) @(posedge pclk);
  endtask : fire

  // Reset values, strobes, reserved bit and an unmapped address.
  task automatic t_regs();
    chk("out_rst", 32'h0000_0000, out_w);
    rd("nfen_rst", tofl_pkg::ADDR_NFEN, 32'h0000_0000, 1'b0);
    rd("isc_rst", tofl_pkg::ADDR_ISC, 32'h0000_0000, 1'b0);
    rd("tom_rst", tofl_pkg::ADDR_TOM, 32'h0000_0000, 1'b0);
    rd("unmapped", 32'h0000_0100, 32'h0000_0000, 1'b1);
    wr(tofl_pkg::ADDR_TOM, 32'h0000_ffaa, 4'h1);
    rd("tom_low", tofl_pkg::ADDR_TOM, 32'h0000_00aa, 1'b0);
    wr(tofl_pkg::ADDR_TOM, 32'h0000_0056, 4'h3);
    rd("tom_full", tofl_pkg::ADDR_TOM, 32'h0000_0056, 1'b0);
    wr(tofl_pkg::ADDR_NFEN, 32'h0000_00ff, 4'h1);
    rd("nfen_rsvd", tofl_pkg::ADDR_NFEN, 32'h0000_00fb, 1'b0);
  endtask : t_regs

  // Channel 2 master toggles, channel 3 slave is set and reset.
  task automatic t_slave();
    wr(tofl_pkg::ADDR_TOE, 32'h0000_000c, 4'h1);
    wr(tofl_pkg::ADDR_TOM, 32'h0000_0008, 4'h3);
    fire(8'h04);
    chk("out_set", 32'h0000_000c, out_w);
    wr(tofl_pkg::ADDR_TOL, 32'h0000_000c, 4'h1);
    chk("out_pol_held", 32'h0000_000c, out_w);
    rd("tol_rd", tofl_pkg::ADDR_TOL, 32'h0000_000c, 1'b0);
    fire(8'h04);
    chk("out_pol_low", 32'h0000_0000, out_w);
    fire(8'h08);
    chk("out_rst_inv", 32'h0000_0008, out_w);
    wr(tofl_pkg::ADDR_TOL, 32'h0000_0000, 4'h1);
    fire(8'h04);
    chk("out_pol_high", 32'h0000_000c, out_w);
    wr(tofl_pkg::ADDR_TOE, 32'h0000_0000, 4'h1);
    fire(8'h0c);
    chk("out_disabled", 32'h0000_000c, out_w);
    rd("stat", tofl_pkg::ADDR_STAT, 32'h0000_000c, 1'b0);
  endtask : t_slave

  // Synchroniser, filter, channel-7 source and interrupt-0 source.
  task automatic t_inputs();
    wr(tofl_pkg::ADDR_NFEN, 32'h0000_0000, 4'h1);
    pin_lvl <= 8'h01;
    repeat (8) @(posedge pclk);
    chk("cond_sync", 32'h0000_0001, cond_w);
    wr(tofl_pkg::ADDR_NFEN, 32'h0000_0082, 4'h1);
    wr(tofl_pkg::ADDR_ISC, 32'h0000_0002, 4'h1);
    pin_lvl <= 8'h00;
    repeat (8) @(posedge pclk);
    pin_gl <= 8'h03;
    ser_gl <= 1'b1;
    @(posedge pclk);
    pin_gl <= 8'h00;
    ser_gl <= 1'b0;
    seen = 8'h00;
    repeat (10) begin
      @(posedge pclk);
      seen = seen | timer_in_cond;
    end
    chk("glitch", 32'h0000_0001, {24'h00_0000, seen});
    pin_lvl <= 8'h02;
    ser_lvl <= 1'b1;
    repeat (10) @(posedge pclk);
    chk("cond_serial", 32'h0000_0082, cond_w);
    wr(tofl_pkg::ADDR_ISC, 32'h0000_0000, 4'h1);
    repeat (4) @(posedge pclk);
    chk("cond_pin7", 32'h0000_0002, cond_w);
    wr(tofl_pkg::ADDR_ISC, 32'h0000_0001, 4'h1);
    repeat (6) @(posedge pclk);
    chk("int0_serial", 32'h0000_0001, {31'h0000_0000, external_interrupt_0});
    wr(tofl_pkg::ADDR_ISC, 32'h0000_0000, 4'h1);
    repeat (6) @(posedge pclk);
    chk("int0_pin", 32'h0000_0000, {31'h0000_0000, external_interrupt_0});
  endtask : t_inputs

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  // Main sequence after a six-cycle reset.
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, ser_lvl, ser_gl, int_lvl} = 6'h00;
    {paddr, pwdata} = 64'h0000_0000_0000_0000;
    pstrb = 4'h0;
    {irq, pin_lvl, pin_gl} = 24'h00_0000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_slave();
    t_inputs();
    close_out();
  end

  // Watchdog against a hang.
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    close_out();
  end
endmodule : tofl_top_bench
